//--- design/atid_edge_det.sv
// rising edge detector on the selected trigger flag
`timescale 1ns/1ps
module atid_edge_det (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  atid_trig_if.det  tif
);
  typedef struct packed {
    logic prev;
    logic trig;
  } atid_det_st_t;

  atid_det_st_t s_q;
  atid_det_st_t s_d;

  always_comb begin
    s_d      = s_q;
    // a selection switch from a low to a high flag also rises here
    s_d.prev = tif.sel_flag & ~tif.free_mode; // RQ16 RQ4 RQ6
    s_d.trig = tif.armed & ~tif.free_mode & tif.sel_flag & ~s_q.prev; // RQ3 RQ4 RQ5 RQ6 RQ16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tif.trig = s_q.trig;
endmodule : atid_edge_det

//--- design/atid_pkg.sv
// constants for the converter trigger and input disable block
// Function
// RQ1: enable set: source field picks trigger flag
// RQ2: enable clear: source field ignored
// RQ3: rising edge of selected flag triggers
// RQ4: switch from low to high source is edge
// RQ5: edge starts conversion only if converter enabled
// RQ6: free running code never triggers
// RQ7: codes 0,1,2: free, comparator, interrupt 0
// RQ8: codes 3,4: timer0 compare A, overflow
// RQ9: codes 5,6,7: timer1 compare B, overflow, capture
// RQ10: software writes zero to reserved control bits
// RQ11: disable bit turns off pin input buffer
// RQ12: disabled pin reads zero in port value
// RQ13: software writes zero to upper disable bits
// RQ14: software should disable analog-only pin buffers
// RQ15: no disable control for pins six, seven
// RQ16: sample flag each cycle, pulse on rise
package atid_pkg;
  localparam logic [3:0] ADDR_TRIG_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_PIN_DISABLE = 4'h4;
  localparam logic [3:0] ADDR_CONV_CTRL   = 4'h8;
  localparam logic [3:0] ADDR_STATUS      = 4'hc;
  localparam int         SRC_LSB          = 0;
  localparam int         SRC_W            = 3;
  localparam int         CMUX_BIT         = 6;
  localparam int         NPINS            = 6;
  localparam int         CONV_EN_BIT      = 7;
  localparam int         AUTO_EN_BIT      = 5;
  localparam logic [7:0] TRIG_CTRL_MASK   = 8'h47;
  localparam logic [7:0] PIN_MASK         = 8'h3f;
  localparam logic [7:0] CONV_CTRL_MASK   = 8'ha0;
  localparam logic [7:0] RESET_VAL        = 8'h00;
  localparam logic [2:0] SRC_FREE         = 3'h0;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;
endpackage : atid_pkg

//--- design/atid_top.sv
// converter auto-trigger selection and analog pin input disable, axi4-lite slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module atid_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        flag_comparator,
  input  wire logic        flag_ext_int0,
  input  wire logic        flag_t0_cmp_a,
  input  wire logic        flag_t0_ovf,
  input  wire logic        flag_t1_cmp_b,
  input  wire logic        flag_t1_ovf,
  input  wire logic        flag_t1_capture,
  input  wire logic [5:0]  pin_raw,
  output logic             conv_start,
  output logic [5:0]       pin_buffer_off_bits,
  output logic [5:0]       pin_value,
  output logic             comparator_mux_enable
);
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  trig_ctrl;
    logic [7:0]  pin_dis;
    logic [7:0]  conv_ctrl;
    logic        conv_start;
    logic        started;
    logic [5:0]  pin_val;
  } atid_st_t;

  atid_st_t    s_q;
  atid_st_t    s_d;
  atid_trig_if tif ();
  logic [7:0]  flags;
  logic [2:0]  src;

  // index equals the source code; code zero carries no flag
  assign flags = {flag_t1_capture, flag_t1_ovf, flag_t1_cmp_b, flag_t0_ovf,
                  flag_t0_cmp_a, flag_ext_int0, flag_comparator, 1'b0}; // RQ7 RQ8 RQ9
  assign src   = s_q.trig_ctrl[atid_pkg::SRC_LSB +: atid_pkg::SRC_W];

  assign tif.sel_flag  = flags[src]; // RQ1
  assign tif.free_mode = (src == atid_pkg::SRC_FREE); // RQ6
  assign tif.armed     = s_q.conv_ctrl[atid_pkg::AUTO_EN_BIT]
                       & s_q.conv_ctrl[atid_pkg::CONV_EN_BIT]; // RQ2 RQ5

  atid_edge_det u_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tif     (tif)
  );

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] wd,
                                       input logic [3:0] st, input logic [7:0] mask);
    merge = st[0] ? (wd[7:0] & mask) : old;
  endfunction : merge

  function automatic logic [31:0] rd_word(input logic [3:0] a, input atid_st_t s);
    rd_word = '0;
    unique case (a)
      atid_pkg::ADDR_TRIG_CTRL:   rd_word[7:0] = s.trig_ctrl; // RQ10
      atid_pkg::ADDR_PIN_DISABLE: rd_word[7:0] = s.pin_dis; // RQ13
      atid_pkg::ADDR_CONV_CTRL:   rd_word[7:0] = s.conv_ctrl;
      atid_pkg::ADDR_STATUS:      rd_word[0]   = s.started;
      default:                    rd_word      = '0;
    endcase
  endfunction : rd_word

  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a[31:4] == '0) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  logic do_write;
  assign do_write = s_q.aw_got & s_q.w_got & ~s_q.bvalid;

  always_comb begin
    s_d = s_q;
    s_d.conv_start = tif.trig; // RQ5
    if (tif.trig) begin
      s_d.started = 1'b1;
    end
    // write channel: address and data taken in either order
    s_d.awready = ~s_q.aw_got & ~s_q.awready & s_axi_awvalid;
    s_d.wready  = ~s_q.w_got & ~s_q.wready & s_axi_wvalid;
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = addr_ok(s_axi_awaddr) ? s_axi_awaddr[3:0] : 4'hf;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = atid_pkg::RESP_OKAY;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      unique case (s_q.aw_addr)
        atid_pkg::ADDR_TRIG_CTRL:
          s_d.trig_ctrl = merge(s_q.trig_ctrl, s_q.wdata, s_q.wstrb, atid_pkg::TRIG_CTRL_MASK); // RQ10
        atid_pkg::ADDR_PIN_DISABLE:
          s_d.pin_dis = merge(s_q.pin_dis, s_q.wdata, s_q.wstrb, atid_pkg::PIN_MASK); // RQ13 RQ15
        atid_pkg::ADDR_CONV_CTRL:
          s_d.conv_ctrl = merge(s_q.conv_ctrl, s_q.wdata, s_q.wstrb, atid_pkg::CONV_CTRL_MASK);
        atid_pkg::ADDR_STATUS: begin
          // write one clears; a start in this same cycle wins
          if (s_q.wstrb[0] && s_q.wdata[0] && !tif.trig) begin
            s_d.started = 1'b0;
          end
        end
        default: s_d.bresp = atid_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // read channel
    s_d.arready = ~s_q.arready & ~s_q.rvalid & s_axi_arvalid;
    if (s_q.arready && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      if (addr_ok(s_axi_araddr)) begin
        s_d.rdata = rd_word(s_axi_araddr[3:0], s_q);
        s_d.rresp = atid_pkg::RESP_OKAY;
      end else begin
        s_d.rdata = '0;
        s_d.rresp = atid_pkg::RESP_SLVERR;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // per-pin buffer gating; a disabled pin reads zero
  for (genvar i = 0; i < atid_pkg::NPINS; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_value[i] <= 1'b0;
      end else if (ce) begin
        pin_value[i] <= pin_raw[i] & ~s_q.pin_dis[i]; // RQ11 RQ12
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.trig_ctrl <= atid_pkg::RESET_VAL;
      s_q.pin_dis   <= atid_pkg::RESET_VAL;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // bit is a register output flop, gated on its own next value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_buffer_off_bits   <= '0;
      comparator_mux_enable <= 1'b0;
    end else if (ce) begin
      pin_buffer_off_bits   <= s_d.pin_dis[atid_pkg::NPINS-1:0]; // RQ11 RQ15
      comparator_mux_enable <= s_d.trig_ctrl[atid_pkg::CMUX_BIT];
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign conv_start    = s_q.conv_start;
endmodule : atid_top

//--- design/atid_trig_if.sv
// selected-flag and trigger pulse carrier between top and edge detector
`timescale 1ns/1ps
interface atid_trig_if;
  logic       sel_flag;
  logic       free_mode;
  logic       armed;
  logic       trig;
  modport top (output sel_flag, output free_mode, output armed, input trig);
  modport det (input sel_flag, input free_mode, input armed, output trig);
endinterface : atid_trig_if

//--- tb/atid_flag_src.sv
// event flag source standing in for the peripherals that feed the trigger selector
`timescale 1ns/1ps
module atid_flag_src (
  input  wire logic       aclk,
  input  wire logic [7:1] req,
  output logic      [7:1] flags
);
  // flags change only after an edge, like real status bits
  always_ff @(posedge aclk) flags <= req;
endmodule : atid_flag_src

//--- tb/atid_top_props.sv
// port-level assertions for the trigger and input disable block
`timescale 1ns/1ps
module atid_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        conv_start,
  input wire logic [5:0]  pin_buffer_off_bits,
  input wire logic [5:0]  pin_value
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  a_pin_masked_zero: assert property ((pin_value & pin_buffer_off_bits & $past(pin_buffer_off_bits)) == 6'h00)
    else $error("disabled pin reads nonzero");
  a_off_bits_hold: assert property (!$rose(s_axi_bvalid) |-> $stable(pin_buffer_off_bits))
    else $error("disable bits changed without a write");
  a_start_single: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_start_after_reset: assert property (!$past(aresetn) |-> !conv_start && pin_buffer_off_bits == 6'h00)
    else $error("outputs not cleared by reset");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : atid_top_props
bind atid_top atid_top_props u_props (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .conv_start(conv_start),
  .pin_buffer_off_bits(pin_buffer_off_bits), .pin_value(pin_value));

//--- tb/atid_top_test.sv
// self-checking bench for the trigger and input disable block
`timescale 1ns/1ps
module atid_top_test;
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, start, cmux;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd_d;
  logic [1:0]  bresp, rresp, rd_r;
  logic [7:1]  req = 7'h00, fl;
  logic [5:0]  raw = 6'h00, off, pv;
  int          n_fail = 0, tests_run = 0, n_start = 0, cyc = 0, n0;
  always #20 aclk = ~aclk;
  atid_flag_src u_src (.aclk(aclk), .req(req), .flags(fl));
  atid_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flag_comparator(fl[1]),
    .flag_ext_int0(fl[2]), .flag_t0_cmp_a(fl[3]), .flag_t0_ovf(fl[4]), .flag_t1_cmp_b(fl[5]),
    .flag_t1_ovf(fl[6]), .flag_t1_capture(fl[7]), .pin_raw(raw), .conv_start(start),
    .pin_buffer_off_bits(off), .pin_value(pv), .comparator_mux_enable(cmux));
  task automatic wrap_up();
    $display("checks %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(posedge aclk) begin
    cyc++;
    if (start === 1'h1) n_start++;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done  = 1'h0;
    awaddr <= {24'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // local flags: the nba to awvalid is not yet visible in this time step
    do begin
      @(posedge aclk);
      if (!aw_done && awready === 1'h1) begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_done && wready === 1'h1) begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    // one idle edge so a following call never re-drives bready in the same step
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= {24'h0, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  // raise one flag for a few cycles and count the starts it causes
  task automatic pulse(input int c, input int exp);
    n0 = n_start;
    req[c] <= 1'h1;
    repeat (4) @(posedge aclk);
    req <= 7'h00;
    repeat (4) @(posedge aclk);
    chk("starts", 32'(n_start - n0), 32'(exp));
  endtask : pulse
  task automatic t_regs();
    rd(8'h00); chk("ctrl reset", rd_d, 32'h0);
    rd(8'h04); chk("disable reset", rd_d, 32'h0);
    wr(8'h00, 8'h47); rd(8'h00); chk("ctrl", rd_d, 32'h47);
    chk("cmux", 32'(cmux), 32'h1);
    wr(8'h04, 8'h3f); rd(8'h04); chk("disable", rd_d, 32'h3f);
    chk("off bits", 32'(off), 32'h3f);
    rd(8'h10); chk("unmapped", 32'(rd_r), 32'h2);
    chk("unmapped data", rd_d, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_pins();
    wr(8'h04, 8'h15);
    raw <= 6'h3f;
    repeat (3) @(posedge aclk);
    chk("pin value", 32'(pv), 32'h2a);
    wr(8'h04, 8'h00);
    repeat (3) @(posedge aclk);
    chk("pin value", 32'(pv), 32'h3f);
    $display("t_pins done");
  endtask : t_pins
  task automatic t_codes();
    wr(8'h08, 8'ha0);
    for (int c = 1; c < 8; c++) begin
      wr(8'h00, 8'(c));
      pulse(c, 1);
      pulse(c % 7 + 1, 0);
    end
    wr(8'h00, 8'h00);
    pulse(1, 0);
    $display("t_codes done");
  endtask : t_codes
  task automatic t_gate();
    wr(8'h08, 8'h80);
    wr(8'h00, 8'h03);
    pulse(3, 0);
    wr(8'h08, 8'h20);
    pulse(3, 0);
    wr(8'h08, 8'ha0);
    $display("t_gate done");
  endtask : t_gate
  task automatic t_switch();
    wr(8'h00, 8'h02);
    req[1] <= 1'h1;
    repeat (3) @(posedge aclk);
    n0 = n_start;
    wr(8'h00, 8'h01);
    repeat (4) @(posedge aclk);
    chk("switch start", 32'(n_start - n0), 32'h1);
    req <= 7'h00;
    rd(8'h0c); chk("start seen", rd_d, 32'h1);
    wr(8'h0c, 8'h01); rd(8'h0c); chk("start cleared", rd_d, 32'h0);
    $display("t_switch done");
  endtask : t_switch
  task automatic t_reset();
    wr(8'h04, 8'h3f);
    wr(8'h00, 8'h41);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("off after reset", 32'(off), 32'h0);
    chk("cmux after reset", 32'(cmux), 32'h0);
    rd(8'h00); chk("ctrl after reset", rd_d, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_pins();
    t_codes();
    t_gate();
    t_switch();
    t_reset();
    wrap_up();
  end
endmodule : atid_top_test
